/* dv/tb.sv */
/*
 Testbench for the pixel and sync output stage: register access, timing
 pin shapes in each mode and polarity, wide and narrow pixel data.
 Assumes the design files and the receiver model are compiled first.
*/
`timescale 1ns/1ps
module tb;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] rdata;
   logic        pix_valid = 1'b0;
   logic        pix_ready;
   logic [7:0]  pix_luma = 8'h00;
   logic [7:0]  pix_chroma = 8'h00;
   logic        out_ready;
   logic [15:0] pixel_output_bus;
   logic        pixel_out_valid;
   logic        vsync;
   logic        hsync;
   logic        half_clk;
   logic        stall = 1'b0;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          cycles = 0;
   logic [15:0] exp_q[$];
   logic [15:0] rst_tbl[9] = '{16'(vpo_pkg::CTRL_RST),
      16'(vpo_pkg::LSYNC_BEGIN_RST), 16'(vpo_pkg::LSYNC_END_RST),
      16'(vpo_pkg::HACT_BEGIN_RST), 16'(vpo_pkg::HACT_END_RST),
      16'(vpo_pkg::VACT_BEGIN_RST), 16'(vpo_pkg::VACT_END_RST),
      16'(vpo_pkg::LINE_LEN_RST), 16'(vpo_pkg::FIELD_LINES_RST)};
   // Per control value: expected high counts of both pins over one field
   logic [15:0] mode_tbl[9][3] = '{'{16'h00, 16'h78, 16'h54},
      '{16'h04, 16'ha0, 16'h54}, '{16'h08, 16'h78, 16'hc4},
      '{16'h0c, 16'ha0, 16'hc4}, '{16'h01, 16'ha0, 16'ha8},
      '{16'h05, 16'h78, 16'ha8}, '{16'h02, 16'ha0, 16'ha8},
      '{16'h0e, 16'h78, 16'h70}, '{16'h03, 16'h78, 16'h54}};

   always #20 clock = ~clock;

   vpo_output vpo_output_i (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_luma(pix_luma),
      .pix_chroma(pix_chroma), .out_ready(out_ready),
      .pixel_output_bus(pixel_output_bus),
      .pixel_out_valid(pixel_out_valid), .vertical_sync_out(vsync),
      .horizontal_sync_out(hsync), .line_locked_half_clock(half_clk));

   vpo_sink vpo_sink_i (.clock(clock), .rst_n(rst_n), .stall(stall),
      .pixel_output_bus(pixel_output_bus),
      .pixel_out_valid(pixel_out_valid), .out_ready(out_ready));

   // =========================================================
   // Shared tasks
   task automatic end_of_test();
      $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      reg_rd(a, d);
      chk(d, e);
   endtask

   // Counts high cycles of both timing pins over n cycles
   task automatic count_hi(input int n, output logic [15:0] v,
                           output logic [15:0] h);
      v = 16'h0000;
      h = 16'h0000;
      repeat (n) begin
         @(negedge clock);
         v += {15'h0000, vsync};
         h += {15'h0000, hsync};
      end
   endtask

   // Holds a word until the edge at which ready is seen high
   task automatic push(input logic [7:0] y, input logic [7:0] c);
      logic r;
      @(posedge clock);
      pix_valid <= 1'b1;
      pix_luma <= y;
      pix_chroma <= c;
      do begin
         @(negedge clock);
         r = pix_ready;
         @(posedge clock);
      end while (r !== 1'b1);
      pix_valid <= 1'b0;
   endtask

   task automatic drain_chk();
      int k;
      k = 0;
      while (vpo_sink_i.got.size() < exp_q.size() && k < 3000) begin
         @(negedge clock);
         k++;
      end
      chk(16'(vpo_sink_i.got.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < vpo_sink_i.got.size()) begin
            chk(vpo_sink_i.got[i], exp_q[i]);
         end
      end
      vpo_sink_i.got.delete();
      exp_q.delete();
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // =========================================================
   // Main sequence
   initial begin
      logic [15:0] v;
      logic [15:0] h;
      logic        hc;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         reg_chk(4'(i), rst_tbl[i]);
      end
      reg_wr(4'hb, 16'h1234);
      reg_chk(4'hb, 16'h0000);
      // Short line of 20 clocks and field of 14 lines
      reg_wr(vpo_pkg::REG_LINE_LEN, 16'h0014);
      reg_wr(vpo_pkg::REG_FIELD_LINES, 16'h000e);
      reg_wr(vpo_pkg::REG_LSYNC_BEGIN, 16'h0002);
      reg_wr(vpo_pkg::REG_LSYNC_END, 16'h0005);
      reg_wr(vpo_pkg::REG_HACT_BEGIN, 16'h0004);
      reg_wr(vpo_pkg::REG_HACT_END, 16'h0010);
      reg_wr(vpo_pkg::REG_VACT_BEGIN, 16'h0002);
      reg_wr(vpo_pkg::REG_VACT_END, 16'h000a);
      reg_chk(vpo_pkg::REG_HACT_END, 16'h0010);
      repeat (300) @(posedge clock);
      // Read-only positions ignore writes; two reads two clocks apart
      reg_wr(vpo_pkg::REG_HPOS, 16'hffff);
      reg_rd(vpo_pkg::REG_HPOS, v);
      reg_rd(vpo_pkg::REG_HPOS, h);
      chk(16'((h + 16'd20 - v) % 16'd20), 16'h0002);
      chk({15'h0000, v < 16'h0014}, 16'h0001);
      reg_rd(vpo_pkg::REG_VPOS, v);
      chk({15'h0000, v < 16'h000e}, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         @(negedge clock);
         hc = half_clk;
         @(negedge clock);
         chk({15'h0000, half_clk}, {15'h0000, ~hc});
      end
      foreach (mode_tbl[i]) begin
         reg_wr(vpo_pkg::REG_CTRL, mode_tbl[i][0]);
         repeat (4) @(posedge clock);
         count_hi(280, v, h);
         chk(v, mode_tbl[i][1]);
         chk(h, mode_tbl[i][2]);
      end
      // Wide bus with a stalling receiver: buffer fills, nothing lost
      reg_wr(vpo_pkg::REG_CTRL, 16'h0010);
      stall <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         push(8'h20 + 8'(i), 8'h90 + 8'(i));
         exp_q.push_back({8'h20 + 8'(i), 8'h90 + 8'(i)});
      end
      drain_chk();
      // Narrow bus in window mode: start right after a line window ends,
      // so that no word is cut by the window edge and sent twice
      reg_wr(vpo_pkg::REG_CTRL, 16'h0001);
      repeat (2) @(posedge clock);
      @(negedge hsync);
      for (int i = 0; i < 4; i++) begin
         push(8'h40 + 8'(i), 8'ha0 + 8'(i));
         exp_q.push_back({8'ha0 + 8'(i), 8'h00});
         exp_q.push_back({8'h40 + 8'(i), 8'h00});
      end
      drain_chk();
      end_of_test();
   end
endmodule

/* dv/vpo_sink.sv */
/*
 Downstream receiver model: takes samples off the pixel bus.
 Assumes it shares the pixel clock and reset with the output stage.
*/
`timescale 1ns/1ps
module vpo_sink (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        stall,
   input  wire logic [15:0] pixel_output_bus,
   input  wire logic        pixel_out_valid,
   output logic             out_ready
);
   logic [1:0]  phase;
   logic [15:0] got[$];
   // =========================================================
   // Ready pattern: while stalling, ready one cycle in three
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         out_ready <= !stall || (phase == 2'h2);
      end
   end
   // =========================================================
   // Capture: bus and valid are taken on the one pixel clock edge
   always @(posedge clock) begin
      if (rst_n && pixel_out_valid) begin
         got.push_back(pixel_output_bus);
      end
   end
endmodule

/* hw/vpo_buf2.sv */
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module vpo_buf2 (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [15:0] in_data,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [15:0]      out_data
);
   logic [15:0] slot [2];
   logic [15:0] next_slot [2];
   logic        wr_ptr;
   logic        rd_ptr;
   logic [1:0]  count;
   logic        next_wr_ptr;
   logic        next_rd_ptr;
   logic [1:0]  next_count;
   logic        next_in_ready;
   logic        push;
   logic        pop;

   assign out_valid = (count != 2'd0);
   assign out_data  = slot[rd_ptr];

   always_comb begin
      push          = in_valid && in_ready;
      pop           = out_valid && out_ready;
      next_slot[0]  = slot[0];
      next_slot[1]  = slot[1];
      if (push) begin
         next_slot[wr_ptr] = in_data;
      end
      next_wr_ptr   = wr_ptr ^ push;
      next_rd_ptr   = rd_ptr ^ pop;
      next_count    = 2'(count + {1'b0, push} - {1'b0, pop});
      next_in_ready = (next_count != 2'd2);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         slot[0]  <= 16'h0000;
         slot[1]  <= 16'h0000;
         wr_ptr   <= 1'b0;
         rd_ptr   <= 1'b0;
         count    <= 2'd0;
         in_ready <= 1'b1;
      end else begin
         slot[0]  <= next_slot[0];
         slot[1]  <= next_slot[1];
         wr_ptr   <= next_wr_ptr;
         rd_ptr   <= next_rd_ptr;
         count    <= next_count;
         in_ready <= next_in_ready;
      end
   end
endmodule

/* hw/vpo_half_clk.sv */
/*
 Divide-by-two of the pixel clock, driven out as a level.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module vpo_half_clk (
   input  wire logic clock,
   input  wire logic rst_n,
   output logic      half_clk
);
   logic next_half_clk;

   always_comb begin
      next_half_clk = ~half_clk;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         half_clk <= 1'b0;
      end else begin
         half_clk <= next_half_clk;
      end
   end
endmodule

/* hw/vpo_output.sv */
/*
 Pixel and sync output stage: line and field counters, vertical and
 horizontal timing pins in sync or active-window form, narrow or wide
 pixel bus, half-rate clock, and a small register port.
 Assumes the clock input is the line-locked pixel clock and that the
 source and receiver are synchronous to it.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
// Notes on behaviour
// - Select 00 makes the vertical pin a sync pulse six lines long.
// - The field polarity bit sets the vertical sync active level.
// - Select 10 or 01 makes the vertical pin the field active window.
// - The field polarity bit also inverts the field active window.
// - Line sync edges sit at begin and end counts in two-clock steps.
// - The line polarity bit sets the horizontal sync active level.
// - In window mode the horizontal pin marks the programmable line window.
// - The line polarity bit also inverts the line active window.
// - Narrow format puts chroma then luma on the upper eight lines.
// - Wide format puts luma high and Cb or Cr on the low eight lines.
// - A second clock output runs at half the pixel clock rate.
`timescale 1ns/1ps
module vpo_output (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   input  wire logic        pix_valid,
   output logic             pix_ready,
   input  wire logic [7:0]  pix_luma,
   input  wire logic [7:0]  pix_chroma,
   input  wire logic        out_ready,
   output logic [15:0]      pixel_output_bus,
   output logic             pixel_out_valid,
   output logic             vertical_sync_out,
   output logic             horizontal_sync_out,
   output logic             line_locked_half_clock
);
   // =========================================================
   // Register file
   logic [4:0]  ctrl;
   logic [9:0]  line_sync_begin;
   logic [9:0]  line_sync_end;
   logic [10:0] hact_begin;
   logic [10:0] hact_end;
   logic [9:0]  vact_begin;
   logic [9:0]  vact_end;
   logic [10:0] line_len;
   logic [9:0]  field_lines;
   logic [4:0]  next_ctrl;
   logic [9:0]  next_line_sync_begin;
   logic [9:0]  next_line_sync_end;
   logic [10:0] next_hact_begin;
   logic [10:0] next_hact_end;
   logic [9:0]  next_vact_begin;
   logic [9:0]  next_vact_end;
   logic [10:0] next_line_len;
   logic [9:0]  next_field_lines;
   logic [15:0] next_rdata;
   logic [10:0] h_count;
   logic [9:0]  v_count;

   always_comb begin
      next_ctrl            = ctrl;
      next_line_sync_begin = line_sync_begin;
      next_line_sync_end   = line_sync_end;
      next_hact_begin      = hact_begin;
      next_hact_end        = hact_end;
      next_vact_begin      = vact_begin;
      next_vact_end        = vact_end;
      next_line_len        = line_len;
      next_field_lines     = field_lines;
      next_rdata           = 16'h0000;
      if (wr) begin
         case (addr)
            vpo_pkg::REG_CTRL:        next_ctrl = wdata[4:0];
            vpo_pkg::REG_LSYNC_BEGIN: next_line_sync_begin = wdata[9:0];
            vpo_pkg::REG_LSYNC_END:   next_line_sync_end = wdata[9:0];
            vpo_pkg::REG_HACT_BEGIN:  next_hact_begin = wdata[10:0];
            vpo_pkg::REG_HACT_END:    next_hact_end = wdata[10:0];
            vpo_pkg::REG_VACT_BEGIN:  next_vact_begin = wdata[9:0];
            vpo_pkg::REG_VACT_END:    next_vact_end = wdata[9:0];
            vpo_pkg::REG_LINE_LEN:    next_line_len = wdata[10:0];
            vpo_pkg::REG_FIELD_LINES: next_field_lines = wdata[9:0];
            default: ;
         endcase
      end
      if (rd) begin
         case (addr)
            vpo_pkg::REG_CTRL:        next_rdata = {11'h000, ctrl};
            vpo_pkg::REG_LSYNC_BEGIN: next_rdata = {6'h00, line_sync_begin};
            vpo_pkg::REG_LSYNC_END:   next_rdata = {6'h00, line_sync_end};
            vpo_pkg::REG_HACT_BEGIN:  next_rdata = {5'h00, hact_begin};
            vpo_pkg::REG_HACT_END:    next_rdata = {5'h00, hact_end};
            vpo_pkg::REG_VACT_BEGIN:  next_rdata = {6'h00, vact_begin};
            vpo_pkg::REG_VACT_END:    next_rdata = {6'h00, vact_end};
            vpo_pkg::REG_LINE_LEN:    next_rdata = {5'h00, line_len};
            vpo_pkg::REG_FIELD_LINES: next_rdata = {6'h00, field_lines};
            vpo_pkg::REG_VPOS:        next_rdata = {6'h00, v_count};
            vpo_pkg::REG_HPOS:        next_rdata = {5'h00, h_count};
            default:                  next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl            <= vpo_pkg::CTRL_RST;
         line_sync_begin <= vpo_pkg::LSYNC_BEGIN_RST;
         line_sync_end   <= vpo_pkg::LSYNC_END_RST;
         hact_begin      <= vpo_pkg::HACT_BEGIN_RST;
         hact_end        <= vpo_pkg::HACT_END_RST;
         vact_begin      <= vpo_pkg::VACT_BEGIN_RST;
         vact_end        <= vpo_pkg::VACT_END_RST;
         line_len        <= vpo_pkg::LINE_LEN_RST;
         field_lines     <= vpo_pkg::FIELD_LINES_RST;
         rdata           <= 16'h0000;
      end else begin
         ctrl            <= next_ctrl;
         line_sync_begin <= next_line_sync_begin;
         line_sync_end   <= next_line_sync_end;
         hact_begin      <= next_hact_begin;
         hact_end        <= next_hact_end;
         vact_begin      <= next_vact_begin;
         vact_end        <= next_vact_end;
         line_len        <= next_line_len;
         field_lines     <= next_field_lines;
         rdata           <= next_rdata;
      end
   end

   // =========================================================
   // Line and field counters, timing decode
   logic [1:0]  ofs;
   logic        fpol;
   logic        lpol;
   logic        wide;
   logic [10:0] next_h_count;
   logic [9:0]  next_v_count;
   logic [9:0]  lsync_step;
   logic        in_fsync;
   logic        in_lsync;
   logic        in_vact;
   logic        in_hact;
   logic        sync_mode;

   always_comb begin
      ofs       = ctrl[vpo_pkg::CTRL_OFS_LSB +: 2];
      fpol      = ctrl[vpo_pkg::CTRL_FPOL_BIT];
      lpol      = ctrl[vpo_pkg::CTRL_LPOL_BIT];
      wide      = ctrl[vpo_pkg::CTRL_WIDE_BIT];
      sync_mode = (ofs != vpo_pkg::OFS_ACT_A) && (ofs != vpo_pkg::OFS_ACT_B);
      next_h_count = 11'(h_count + 11'd1);
      next_v_count = v_count;
      if (h_count >= 11'(line_len - 11'd1)) begin
         next_h_count = 11'd0;
         next_v_count = 10'(v_count + 10'd1);
         if (v_count >= 10'(field_lines - 10'd1)) begin
            next_v_count = 10'd0;
         end
      end
      in_fsync   = (v_count < vpo_pkg::FSYNC_LINES);
      lsync_step = h_count[vpo_pkg::LSYNC_STEP_LOG2 +: 10];
      if (line_sync_begin <= line_sync_end) begin
         in_lsync = (lsync_step >= line_sync_begin) &&
                    (lsync_step < line_sync_end);
      end else begin
         in_lsync = (lsync_step >= line_sync_begin) ||
                    (lsync_step < line_sync_end);
      end
      in_vact = (v_count >= vact_begin) && (v_count < vact_end);
      in_hact = (h_count >= hact_begin) && (h_count < hact_end);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         h_count <= 11'd0;
         v_count <= 10'd0;
      end else begin
         h_count <= next_h_count;
         v_count <= next_v_count;
      end
   end

   // =========================================================
   // Input buffer and half-rate clock
   logic [15:0] buf_data;
   logic        buf_valid;
   logic        buf_pop;

   vpo_buf2 vpo_buf2_i (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   ({pix_luma, pix_chroma}),
      .out_valid (buf_valid),
      .out_ready (buf_pop),
      .out_data  (buf_data)
   );

   vpo_half_clk vpo_half_clk_i (
      .clock    (clock),
      .rst_n    (rst_n),
      .half_clk (line_locked_half_clock)
   );

   // =========================================================
   // Output registers
   vpo_pkg::vpo_phase_e phase;
   vpo_pkg::vpo_phase_e next_phase;
   logic [15:0] next_bus;
   logic        next_out_valid;
   logic        next_vert_pin;
   logic        next_horz_pin;

   always_comb begin
      next_phase     = phase;
      next_bus       = pixel_output_bus;
      next_out_valid = 1'b0;
      buf_pop        = 1'b0;
      if (sync_mode) begin
         next_vert_pin = in_fsync ^ fpol;
         next_horz_pin = in_lsync ^ lpol;
      end else begin
         next_vert_pin = in_vact ^ fpol;
         next_horz_pin = in_hact ^ lpol;
      end
      if (out_ready) begin
         if (!(in_vact && in_hact)) begin
            next_bus   = {vpo_pkg::BLANK_LUMA, vpo_pkg::BLANK_CHROMA};
            next_phase = vpo_pkg::VPO_PH_CHROMA;
         end else if (buf_valid && wide) begin
            next_bus       = buf_data;
            next_out_valid = 1'b1;
            buf_pop        = 1'b1;
         end else if (buf_valid) begin
            next_out_valid = 1'b1;
            case (phase)
               vpo_pkg::VPO_PH_CHROMA: begin
                  next_bus   = {buf_data[7:0], 8'h00};
                  next_phase = vpo_pkg::VPO_PH_LUMA;
               end
               vpo_pkg::VPO_PH_LUMA: begin
                  next_bus   = {buf_data[15:8], 8'h00};
                  next_phase = vpo_pkg::VPO_PH_CHROMA;
                  buf_pop    = 1'b1;
               end
               default: next_phase = vpo_pkg::VPO_PH_CHROMA;
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase               <= vpo_pkg::VPO_PH_CHROMA;
         pixel_output_bus    <= 16'h0000;
         pixel_out_valid     <= 1'b0;
         vertical_sync_out   <= 1'b0;
         horizontal_sync_out <= 1'b0;
      end else begin
         phase               <= next_phase;
         pixel_output_bus    <= next_bus;
         pixel_out_valid     <= next_out_valid;
         vertical_sync_out   <= next_vert_pin;
         horizontal_sync_out <= next_horz_pin;
      end
   end

   // =========================================================
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // The first edge after reset still shows the reset levels on the pins
   fsync_pulse_a: assert property ($past(rst_n) && $past(sync_mode) |->
      vertical_sync_out == (($past(v_count) < vpo_pkg::FSYNC_LINES) ^
      $past(fpol)))
      else $error("vertical sync pulse wrong");
   fsync_level_a: assert property ($past(rst_n) && $past(sync_mode) &&
      $past(v_count) == 10'h000 |-> vertical_sync_out == !$past(fpol))
      else $error("vertical sync level wrong");
   vact_win_a: assert property (!$past(sync_mode) && !$past(fpol) |->
      vertical_sync_out == $past(in_vact))
      else $error("field window wrong");
   vact_pol_a: assert property (!$past(sync_mode) && $past(fpol) |->
      vertical_sync_out == !$past(in_vact))
      else $error("field window polarity wrong");
   lsync_edge_a: assert property ($past(rst_n) && $past(sync_mode) &&
      !$past(lpol) && $past(line_sync_begin) < $past(line_sync_end) |->
      horizontal_sync_out == ($past(h_count) >= {$past(line_sync_begin),
      1'b0} && $past(h_count) < {$past(line_sync_end), 1'b0}))
      else $error("line sync edges wrong");
   lsync_level_a: assert property ($past(rst_n) && $past(sync_mode) &&
      $past(lpol) |-> horizontal_sync_out == !$past(in_lsync))
      else $error("line sync level wrong");
   hact_win_a: assert property (!$past(sync_mode) |->
      horizontal_sync_out == ($past(in_hact) ^ $past(lpol)))
      else $error("line window wrong");
   narrow_pair_a: assert property (pixel_out_valid && !$past(wide) &&
      phase == vpo_pkg::VPO_PH_LUMA |-> pixel_output_bus[7:0] == 8'h00)
      else $error("narrow lane not clear");
   wide_lane_a: assert property ($past(buf_pop) && $past(wide) |->
      pixel_output_bus == $past(buf_data) && pixel_out_valid)
      else $error("wide lanes wrong");
   half_clk_a: assert property ($past(rst_n) |->
      line_locked_half_clock != $past(line_locked_half_clock))
      else $error("half clock not toggling");

   sync_cov: cover property (sync_mode && v_count == 10'd5 ##1 !in_fsync);
   wide_cov: cover property (wide && buf_pop ##1 pixel_out_valid);
   narrow_cov: cover property (!wide && phase == vpo_pkg::VPO_PH_LUMA
      && buf_pop);
   stall_cov: cover property (!pix_ready ##1 pix_ready);
endmodule

/* hw/vpo_pkg.sv */
/*
 Shared constants for the video pixel and sync output stage: register
 offsets, control field positions, reset values and timing figures.
 Assumes a single line-locked pixel clock drives every user.
*/
package vpo_pkg;
   // =========================================================
   // Register offsets
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_LSYNC_BEGIN = 4'h1;
   localparam logic [3:0]  REG_LSYNC_END   = 4'h2;
   localparam logic [3:0]  REG_HACT_BEGIN  = 4'h3;
   localparam logic [3:0]  REG_HACT_END    = 4'h4;
   localparam logic [3:0]  REG_VACT_BEGIN  = 4'h5;
   localparam logic [3:0]  REG_VACT_END    = 4'h6;
   localparam logic [3:0]  REG_LINE_LEN    = 4'h7;
   localparam logic [3:0]  REG_FIELD_LINES = 4'h8;
   localparam logic [3:0]  REG_VPOS        = 4'h9;
   localparam logic [3:0]  REG_HPOS        = 4'ha;
   // =========================================================
   // Control register fields
   localparam int          CTRL_OFS_LSB    = 0;
   localparam int          CTRL_FPOL_BIT   = 2;
   localparam int          CTRL_LPOL_BIT   = 3;
   localparam int          CTRL_WIDE_BIT   = 4;
   localparam int          CTRL_WIDTH      = 5;
   localparam logic [1:0]  OFS_SYNC        = 2'h0;
   localparam logic [1:0]  OFS_ACT_A       = 2'h1;
   localparam logic [1:0]  OFS_ACT_B       = 2'h2;
   // =========================================================
   // Reset values
   localparam logic [4:0]  CTRL_RST        = 5'h00;
   localparam logic [9:0]  LSYNC_BEGIN_RST = 10'h000;
   localparam logic [9:0]  LSYNC_END_RST   = 10'h020;
   localparam logic [10:0] HACT_BEGIN_RST  = 11'h07a;
   localparam logic [10:0] HACT_END_RST    = 11'h34a;
   localparam logic [9:0]  VACT_BEGIN_RST  = 10'h014;
   localparam logic [9:0]  VACT_END_RST    = 10'h104;
   localparam logic [10:0] LINE_LEN_RST    = 11'h35a;
   localparam logic [9:0]  FIELD_LINES_RST = 10'h107;
   // =========================================================
   // Timing and data figures
   localparam int          CLOCK_NS        = 40;
   localparam logic [9:0]  FSYNC_LINES     = 10'h006;
   localparam int          LSYNC_STEP_CLKS = 2;
   localparam int          LSYNC_STEP_LOG2 = $clog2(LSYNC_STEP_CLKS);
   localparam logic [7:0]  BLANK_LUMA      = 8'h10;
   localparam logic [7:0]  BLANK_CHROMA    = 8'h80;
   // =========================================================
   // Narrow-format sample phase
   typedef enum logic [1:0] {
      VPO_PH_CHROMA = 2'b01,
      VPO_PH_LUMA   = 2'b10
   } vpo_phase_e;
endpackage
